// file: include/field_decode_pkg.sv
// package for the control-structure field identifier decoder
// constants, capability and result carriers shared by design and bench
package field_decode_pkg;

	// identifier bit positions
	localparam int ACC_BIT      = 0;
	localparam int IDX_LO       = 1;
	localparam int IDX_HI       = 9;
	localparam int CLS_LO       = 10;
	localparam int CLS_HI       = 11;
	localparam int WID_LO       = 13;
	localparam int WID_HI       = 14;

	// width codes in bits 14:13
	localparam logic [1:0] WID_64   = 2'h1;
	localparam logic [1:0] WID_32   = 2'h2;

	// class codes in bits 11:10
	localparam logic [1:0] CLS_CTRL  = 2'h0;
	localparam logic [1:0] CLS_RO    = 2'h1;
	localparam logic [1:0] CLS_GUEST = 2'h2;
	localparam logic [1:0] CLS_HOST  = 2'h3;

	// mapped identifiers, full-access form
	localparam logic [31:0] ID_ENCLAVE_EXIT_BITMAP = 32'h0000202E;
	localparam logic [31:0] ID_TIMESTAMP_MULT      = 32'h00002032;
	localparam logic [31:0] ID_GUEST_PHYS_ADDR     = 32'h00002400;
	localparam logic [31:0] ID_LINK_POINTER        = 32'h00002800;
	localparam logic [31:0] ID_DEBUG_CONTROL       = 32'h00002802;
	localparam logic [31:0] ID_GUEST_PAGE_ATTR     = 32'h00002804;
	localparam logic [31:0] ID_GUEST_EXT_FEATURE   = 32'h00002806;
	localparam logic [31:0] ID_GUEST_PERF_CTRL     = 32'h00002808;
	localparam logic [31:0] ID_PDP_ENTRY_FIRST     = 32'h0000280A;
	localparam logic [31:0] ID_PDP_ENTRY_LAST      = 32'h00002810;
	localparam logic [31:0] ID_BOUNDS_CONFIG       = 32'h00002812;
	localparam logic [31:0] ID_HOST_PAGE_ATTR      = 32'h00002C00;
	localparam logic [31:0] ID_HOST_EXT_FEATURE    = 32'h00002C02;
	localparam logic [31:0] ID_HOST_PERF_CTRL      = 32'h00002C04;
	localparam logic [31:0] ID_CTRL32_FIRST        = 32'h00004000;
	localparam logic [31:0] ID_CTRL32_PLAIN_LAST   = 32'h0000401A;
	localparam logic [31:0] ID_TASK_PRIORITY       = 32'h0000401C;
	localparam logic [31:0] ID_SECONDARY_CTRL      = 32'h0000401E;
	localparam logic [31:0] ID_PAUSE_LOOP_GAP      = 32'h00004020;
	localparam logic [31:0] ID_PAUSE_LOOP_WINDOW   = 32'h00004022;

	// reset value of the result index
	localparam logic [8:0] IDX_RESET = 9'h000;

	typedef enum logic [1:0] {
		FIELD_CONTROL,
		FIELD_READ_ONLY,
		FIELD_GUEST,
		FIELD_HOST
	} field_class_t;

	typedef enum logic [1:0] {
		SIZE_NONE,
		SIZE_32,
		SIZE_64
	} field_size_t;

	// which optional 1-settings the core supports
	typedef struct packed {
		logic enclave_instruction_exit;
		logic timestamp_counter_scaling;
		logic extended_page_table;
		logic entry_load_page_attr;
		logic exit_save_page_attr;
		logic entry_load_ext_feature;
		logic exit_save_ext_feature;
		logic entry_load_perf_ctrl;
		logic entry_load_bounds;
		logic exit_clear_bounds;
		logic exit_load_page_attr;
		logic exit_load_ext_feature;
		logic exit_load_perf_ctrl;
		logic task_priority_shadow;
		logic secondary_activation;
		logic pause_loop_exit;
	} capability_t;

	typedef struct packed {
		logic [31:0] id;
		logic        write;
	} request_t;

	typedef struct packed {
		logic         valid;
		logic         supported;
		logic         write_refused;
		field_size_t  size;
		field_class_t cls;
		logic [8:0]   index;
		logic         upper_half;
	} result_t;

endpackage

// file: verilog/field_decoder.sv
// field identifier decoder for the virtual-machine control structure
// assumes requests and capability bits come from logic on the same clock; capabilities stay static
// How it works
// [RULE_01] class 0 in bits 11:10 is control
// [RULE_02] class 1 is read-only; writes refused
// [RULE_03] class 2 is guest state
// [RULE_04] class 3 is host state
// [RULE_05] bits 9:1 pick the field index
// [RULE_06] width code 2 means 32-bit field
// [RULE_07] 32-bit fields need bit 0 clear
// [RULE_08] width code 1 means 64-bit field
// [RULE_09] 64-bit odd identifier accesses upper half
// [RULE_10] read-only 64-bit: guest physical address only
// [RULE_11] enclave bitmap and timestamp multiplier mapped
// [RULE_12] those two depend on their controls
// [RULE_13] guest link, debug, attr, feature, perf mapped
// [RULE_14] guest page-dir entries and bounds mapped
// [RULE_15] physical address, page-dir entries need paging
// [RULE_16] guest attr/feature/bounds need entry or exit
// [RULE_17] host attr, feature, perf need exit loads
// [RULE_18] 32-bit controls 4000 through 4008 mapped
// [RULE_19] 32-bit controls 400A through 401A mapped
// [RULE_20] priority threshold, secondary controls are optional
// [RULE_21] pause-loop fields need pause-loop exiting
// [RULE_22] unmapped, absent or odd 32-bit flagged
`timescale 1ns/1ns

module field_decoder (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_arst_n,
	input  wire logic                        i_clk_en,
	input  wire logic                        i_req_valid,
	input  wire field_decode_pkg::request_t  i_req,
	input  wire field_decode_pkg::capability_t i_cap,
	output logic                             o_valid,
	output logic                             o_supported,
	output logic                             o_write_refused,
	output field_decode_pkg::field_size_t    o_size,
	output field_decode_pkg::field_class_t   o_class,
	output logic [8:0]                       o_index,
	output logic                             o_upper_half
);

	typedef struct packed {
		field_decode_pkg::result_t res;
	} state_t;

	state_t state;
	state_t next_state;

	// class code in bits 11:10; every code names a class
	function automatic field_decode_pkg::field_class_t class_of(input logic [1:0] code);
		field_decode_pkg::field_class_t k;
		case (code)
			field_decode_pkg::CLS_CTRL: begin
				k = field_decode_pkg::FIELD_CONTROL; // RULE_01
			end
			field_decode_pkg::CLS_RO: begin
				k = field_decode_pkg::FIELD_READ_ONLY; // RULE_02
			end
			field_decode_pkg::CLS_GUEST: begin
				k = field_decode_pkg::FIELD_GUEST; // RULE_03
			end
			field_decode_pkg::CLS_HOST: begin
				k = field_decode_pkg::FIELD_HOST; // RULE_04
			end
			default: begin
				k = field_decode_pkg::FIELD_CONTROL;
			end
		endcase
		return k;
	endfunction

	// width code in bits 14:13; 16-bit and natural-width belong elsewhere
	function automatic field_decode_pkg::field_size_t size_of(input logic [1:0] code);
		field_decode_pkg::field_size_t s;
		case (code)
			field_decode_pkg::WID_64: begin
				s = field_decode_pkg::SIZE_64; // RULE_08
			end
			field_decode_pkg::WID_32: begin
				s = field_decode_pkg::SIZE_32; // RULE_06
			end
			default: begin
				s = field_decode_pkg::SIZE_NONE;
			end
		endcase
		return s;
	endfunction

	// 64-bit control fields of this block, even identifier
	function automatic logic exists_ctrl64(input logic [31:0]                  id,
	                                       input field_decode_pkg::capability_t c);
		logic ok;
		ok = 1'b0;
		case (id)
			field_decode_pkg::ID_ENCLAVE_EXIT_BITMAP: begin
				ok = c.enclave_instruction_exit; // RULE_11 RULE_12
			end
			field_decode_pkg::ID_TIMESTAMP_MULT: begin
				ok = c.timestamp_counter_scaling; // RULE_11 RULE_12
			end
			default: begin
				// earlier control entries are decoded by a neighbouring block
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	// the single 64-bit read-only field
	function automatic logic exists_ro64(input logic [31:0]                  id,
	                                     input field_decode_pkg::capability_t c);
		logic ok;
		ok = 1'b0;
		case (id)
			field_decode_pkg::ID_GUEST_PHYS_ADDR: begin
				ok = c.extended_page_table; // RULE_10 RULE_15
			end
			default: begin
				ok = 1'b0; // RULE_10
			end
		endcase
		return ok;
	endfunction

	// 64-bit guest-state fields; entry or exit side alone is enough
	function automatic logic exists_guest64(input logic [31:0]                  id,
	                                        input field_decode_pkg::capability_t c);
		logic ok;
		ok = 1'b0;
		case (id)
			field_decode_pkg::ID_LINK_POINTER: begin
				ok = 1'b1; // RULE_13
			end
			field_decode_pkg::ID_DEBUG_CONTROL: begin
				ok = 1'b1; // RULE_13
			end
			field_decode_pkg::ID_GUEST_PAGE_ATTR: begin
				ok = c.entry_load_page_attr | c.exit_save_page_attr; // RULE_13 RULE_16
			end
			field_decode_pkg::ID_GUEST_EXT_FEATURE: begin
				ok = c.entry_load_ext_feature | c.exit_save_ext_feature; // RULE_13 RULE_16
			end
			field_decode_pkg::ID_GUEST_PERF_CTRL: begin
				// only an entry-side load control exists for this one
				ok = c.entry_load_perf_ctrl; // RULE_13
			end
			field_decode_pkg::ID_BOUNDS_CONFIG: begin
				ok = c.entry_load_bounds | c.exit_clear_bounds; // RULE_14 RULE_16
			end
			default: begin
				// four page-dir entries in steps of two; caller passes even ids only
				if (id >= field_decode_pkg::ID_PDP_ENTRY_FIRST &&
				    id <= field_decode_pkg::ID_PDP_ENTRY_LAST) begin
					ok = c.extended_page_table; // RULE_14 RULE_15
				end
			end
		endcase
		return ok;
	endfunction

	// 64-bit host-state fields, each tied to its exit load control
	function automatic logic exists_host64(input logic [31:0]                  id,
	                                       input field_decode_pkg::capability_t c);
		logic ok;
		ok = 1'b0;
		case (id)
			field_decode_pkg::ID_HOST_PAGE_ATTR: begin
				ok = c.exit_load_page_attr; // RULE_17
			end
			field_decode_pkg::ID_HOST_EXT_FEATURE: begin
				ok = c.exit_load_ext_feature; // RULE_17
			end
			field_decode_pkg::ID_HOST_PERF_CTRL: begin
				ok = c.exit_load_perf_ctrl; // RULE_17
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	// 64-bit existence, split by class so each table stays small
	function automatic logic exists64(input logic [31:0]                  id,
	                                  input field_decode_pkg::capability_t c);
		logic ok;
		ok = 1'b0;
		case (id[field_decode_pkg::CLS_HI:field_decode_pkg::CLS_LO])
			field_decode_pkg::CLS_CTRL: begin
				ok = exists_ctrl64(id, c);
			end
			field_decode_pkg::CLS_RO: begin
				ok = exists_ro64(id, c);
			end
			field_decode_pkg::CLS_GUEST: begin
				ok = exists_guest64(id, c);
			end
			field_decode_pkg::CLS_HOST: begin
				ok = exists_host64(id, c);
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	// 32-bit control fields; the optional ones sit at the top of the table
	function automatic logic exists_ctrl32(input logic [31:0]                  id,
	                                       input field_decode_pkg::capability_t c);
		logic ok;
		ok = 1'b0;
		case (id)
			field_decode_pkg::ID_TASK_PRIORITY: begin
				ok = c.task_priority_shadow; // RULE_20
			end
			field_decode_pkg::ID_SECONDARY_CTRL: begin
				ok = c.secondary_activation; // RULE_20
			end
			field_decode_pkg::ID_PAUSE_LOOP_GAP: begin
				ok = c.pause_loop_exit; // RULE_21
			end
			field_decode_pkg::ID_PAUSE_LOOP_WINDOW: begin
				ok = c.pause_loop_exit; // RULE_21
			end
			default: begin
				// caller has already refused odd identifiers
				if (id >= field_decode_pkg::ID_CTRL32_FIRST &&
				    id <= field_decode_pkg::ID_CTRL32_PLAIN_LAST) begin
					ok = 1'b1; // RULE_18 RULE_19
				end
			end
		endcase
		return ok;
	endfunction

	// 32-bit existence; other classes are decoded by a neighbouring block
	function automatic logic exists32(input logic [31:0]                  id,
	                                  input field_decode_pkg::capability_t c);
		logic ok;
		ok = 1'b0;
		if (id[field_decode_pkg::ACC_BIT]) begin
			ok = 1'b0; // RULE_07
		end else if (id[field_decode_pkg::CLS_HI:field_decode_pkg::CLS_LO] ==
		             field_decode_pkg::CLS_CTRL) begin
			ok = exists_ctrl32(id, c); // RULE_18 RULE_19
		end
		return ok;
	endfunction

	// one request in, one result out; nothing here depends on state
	function automatic field_decode_pkg::result_t decode(
		input field_decode_pkg::request_t    r,
		input field_decode_pkg::capability_t c
	);
		field_decode_pkg::result_t res;
		logic [31:0]               even_id;
		logic [1:0]                wid;
		logic [1:0]                cls;
		logic                      mapped;
		even_id        = {r.id[31:1], 1'b0};
		wid            = r.id[field_decode_pkg::WID_HI:field_decode_pkg::WID_LO];
		cls            = r.id[field_decode_pkg::CLS_HI:field_decode_pkg::CLS_LO];
		mapped         = 1'b0;
		res.valid      = 1'b1;
		res.size       = size_of(wid);
		res.cls        = class_of(cls);
		res.index      = r.id[field_decode_pkg::IDX_HI:field_decode_pkg::IDX_LO]; // RULE_05
		res.upper_half = 1'b0;
		case (wid)
			field_decode_pkg::WID_64: begin
				// both halves share existence of the even identifier
				res.upper_half = r.id[field_decode_pkg::ACC_BIT]; // RULE_09
				mapped         = exists64(even_id, c); // RULE_09
			end
			field_decode_pkg::WID_32: begin
				mapped = exists32(r.id, c); // RULE_07
			end
			default: begin
				mapped = 1'b0; // RULE_22
			end
		endcase
		res.supported     = mapped; // RULE_22
		// refusal only reported for fields that would otherwise exist
		res.write_refused = mapped && r.write && cls == field_decode_pkg::CLS_RO; // RULE_02
		return res;
	endfunction

	always_comb begin
		next_state           = state;
		next_state.res.valid = 1'b0;
		if (i_req_valid) begin
			next_state.res = decode(i_req, i_cap);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state.res.valid         <= 1'b0;
			state.res.supported     <= 1'b0;
			state.res.write_refused <= 1'b0;
			state.res.size          <= field_decode_pkg::SIZE_NONE;
			state.res.cls           <= field_decode_pkg::FIELD_CONTROL;
			state.res.index         <= field_decode_pkg::IDX_RESET;
			state.res.upper_half    <= 1'b0;
		end else if (i_clk_en) begin
			state <= next_state;
		end
	end

	assign o_valid         = state.res.valid;
	assign o_supported     = state.res.supported;
	assign o_write_refused = state.res.write_refused;
	assign o_size          = state.res.size;
	assign o_class         = state.res.cls;
	assign o_index         = state.res.index;
	assign o_upper_half    = state.res.upper_half;

endmodule

// file: bench/field_decoder_monitor.sv
// port assertions for the field decoder
// bound to every field_decoder; single clock domain
`timescale 1ns/1ns
module field_decoder_monitor (
	input wire logic                           i_ref_clk,
	input wire logic                           i_arst_n,
	input wire logic                           i_clk_en,
	input wire logic                           i_req_valid,
	input wire field_decode_pkg::request_t     i_req,
	input wire field_decode_pkg::capability_t  i_cap,
	input wire logic                           o_valid,
	input wire logic                           o_supported,
	input wire logic                           o_write_refused,
	input wire field_decode_pkg::field_size_t  o_size,
	input wire field_decode_pkg::field_class_t o_class,
	input wire logic [8:0]                     o_index,
	input wire logic                           o_upper_half
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	wire t = i_clk_en && i_req_valid;
	wire [1:0] w = i_req.id[14:13];
	property p_cls; t |=> o_class == $past(i_req.id[11:10]); endproperty
	a_cls: assert property (p_cls) else $error("bad class");
	property p_idx; t |=> o_valid && o_index == $past(i_req.id[9:1]); endproperty
	a_idx: assert property (p_idx) else $error("bad index");
	property p_s32; t && w == 2'h2 |=> o_size == field_decode_pkg::SIZE_32; endproperty
	a_s32: assert property (p_s32) else $error("bad 32 size");
	property p_odd; t && w == 2'h2 && i_req.id[0] |=> !o_supported; endproperty
	a_odd: assert property (p_odd) else $error("odd 32 taken");
	property p_s64; t && w == 2'h1 |=> o_size == field_decode_pkg::SIZE_64; endproperty
	a_s64: assert property (p_s64) else $error("bad 64 size");
	property p_up; t && w == 2'h1 |=> o_upper_half == $past(i_req.id[0]); endproperty
	a_up: assert property (p_up) else $error("bad half");
	property p_gpa;
		t && i_req.id[31:1] == 31'h00001200 |=> o_supported == $past(i_cap.extended_page_table);
	endproperty
	a_gpa: assert property (p_gpa) else $error("bad fault addr");
	property p_ro; t && i_req.id[11:10] == 2'h1 && i_req.write |=> o_write_refused == o_supported;
	endproperty
	a_ro: assert property (p_ro) else $error("write not refused");
	property p_none; t && w inside {2'h0, 2'h3} |=> !o_supported; endproperty
	a_none: assert property (p_none) else $error("bad width taken");
	property p_hold; i_clk_en && !i_req_valid |=> !o_valid && $stable(o_index); endproperty
	a_hold: assert property (p_hold) else $error("no hold");
	c_wr: cover property (t && i_req.write);
	c_uns: cover property (o_valid && !o_supported);
	c_ref: cover property (o_write_refused);
endmodule
bind field_decoder field_decoder_monitor u_mon (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
	.i_clk_en(i_clk_en), .i_req_valid(i_req_valid), .i_req(i_req), .i_cap(i_cap),
	.o_valid(o_valid), .o_supported(o_supported), .o_write_refused(o_write_refused),
	.o_size(o_size), .o_class(o_class), .o_index(o_index), .o_upper_half(o_upper_half));

// file: bench/field_requester.sv
// requester model standing for the core's field access logic
// bench calls its tasks on the falling edge
`timescale 1ns/1ns
module field_requester (
	output logic                       o_req_valid,
	output field_decode_pkg::request_t o_req
);
	initial begin
		o_req_valid = 1'b0;
		o_req = '0;
	end
	task put(input logic [31:0] id, input logic wr);
		o_req_valid = 1'b1;
		o_req = '{id: id, write: wr};
	endtask
	// idle id inverted so a stale value never looks valid
	task idle();
		o_req_valid = 1'b0;
		o_req.id = ~o_req.id;
	endtask
endmodule

// file: bench/field_decoder_tb.sv
// self-checking bench for the field decoder
// requester model drives ids; expectations come from the field map below
`timescale 1ns/1ns
module field_decoder_tb;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_clk_en = 1'b1;
	logic rv, o_valid, o_supported, o_write_refused, o_upper_half;
	logic [8:0] o_index;
	logic [31:0] id;
	field_decode_pkg::request_t rq;
	field_decode_pkg::capability_t cap = '1;
	field_decode_pkg::field_size_t o_size;
	field_decode_pkg::field_class_t o_class;
	field_decode_pkg::result_t e;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	// bit 18: exists with all caps, 17: with none, 16: with only the three exit save/clear caps
	localparam logic [18:0] MAP [36] = '{
		19'h4202E, 19'h4202F, 19'h42032, 19'h42033,
		19'h42400, 19'h42401, 19'h72800, 19'h72803, 19'h52804, 19'h52806,
		19'h42808, 19'h4280A, 19'h42810, 19'h52813,
		19'h42C00, 19'h42C02, 19'h42C05,
		19'h74000, 19'h74004, 19'h74008, 19'h7400A, 19'h7401A,
		19'h4401C, 19'h4401E, 19'h44020, 19'h44022,
		19'h02030, 19'h04001, 19'h04024, 19'h02C06, 19'h02814, 19'h02402,
		19'h00800, 19'h06000, 19'h0401B, 19'h02031};
	// enabling capability bits per MAP entry, capability_t order; zero means none needed
	localparam logic [15:0] NEED [36] = '{
		16'h8000, 16'h8000, 16'h4000, 16'h4000,
		16'h2000, 16'h2000, 16'h0000, 16'h0000, 16'h1800, 16'h0600,
		16'h0100, 16'h2000, 16'h2000, 16'h00C0,
		16'h0020, 16'h0010, 16'h0008,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0004, 16'h0002, 16'h0001, 16'h0001,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	always #5 i_ref_clk = ~i_ref_clk;
	field_requester core (.o_req_valid(rv), .o_req(rq));
	field_decoder dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
		.i_req_valid(rv), .i_req(rq), .i_cap(cap), .o_valid(o_valid),
		.o_supported(o_supported), .o_write_refused(o_write_refused), .o_size(o_size),
		.o_class(o_class), .o_index(o_index), .o_upper_half(o_upper_half));
	task give_verdict();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check();
		n_tests++;
		if ({o_valid, o_supported, o_write_refused, o_size, o_class, o_index,
			o_upper_half} !== e) begin
			error_cnt++;
			$display("wrong value at %0t: id %h", $time, rq.id);
		end
	endtask
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		repeat (5) @(negedge i_ref_clk);
		i_arst_n = 1'b1;
		for (int p = 0; p < 19; p++) begin
			// passes 3 and up walk one capability bit so a swapped control shows
			if (p < 3) begin
				cap = (p == 0) ? '1 : '0;
				cap.exit_save_page_attr = p != 1;
				cap.exit_save_ext_feature = p != 1;
				cap.exit_clear_bounds = p != 1;
			end else begin
				cap = field_decode_pkg::capability_t'(16'h0001 << (p - 3));
			end
			for (int k = 0; k < 72; k++) begin
				id = {16'h0000, MAP[k / 2][15:0]};
				core.put(id, k[0]);
				@(negedge i_ref_clk);
				e.valid = 1'b1;
				if (p < 3)
					e.supported = MAP[k / 2][18 - p];
				else
					e.supported = MAP[k / 2][17] | (|(NEED[k / 2] & cap));
				e.write_refused = e.supported && id[11:10] == 2'h1 && k[0];
				e.size = id[14:13] == 2'h1 ? field_decode_pkg::SIZE_64 :
					id[14:13] == 2'h2 ? field_decode_pkg::SIZE_32 : field_decode_pkg::SIZE_NONE;
				e.cls = field_decode_pkg::field_class_t'(id[11:10]);
				e.index = id[9:1];
				e.upper_half = id[14:13] == 2'h1 && id[0];
				check();
			end
			$display("capability pass %0d done", p);
		end
		i_clk_en = 1'b0;
		core.idle();
		@(negedge i_ref_clk);
		check();
		i_clk_en = 1'b1;
		@(negedge i_ref_clk);
		e.valid = 1'b0;
		check();
		@(negedge i_ref_clk);
		check();
		$display("hold test done");
		give_verdict();
	end
endmodule
